// *** qca_pkg.sv ***
// constants and types for one compensated quadrature axis
package qca_pkg;
  // ------------------------------------------------------------
  // clock and rates
  // ------------------------------------------------------------
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          IN_RATE_HZ  = 2_500_000;
  localparam int          OUT_RATE_HZ = 2_500_000;
  localparam logic [7:0]  IN_DIV_RST  = 8'(CLK_HZ / IN_RATE_HZ);
  localparam logic [7:0]  OUT_DIV_RST = 8'(CLK_HZ / OUT_RATE_HZ);
  localparam int          CNT_W       = 32;
  // ------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------
  localparam logic [3:0]  A_CTRL   = 4'h0;
  localparam logic [3:0]  A_RATE   = 4'h1;
  localparam logic [3:0]  A_RES    = 4'h2;
  localparam logic [3:0]  A_COMP01 = 4'h3;
  localparam logic [3:0]  A_COMP23 = 4'h4;
  localparam logic [3:0]  A_STAT   = 4'h5;
  localparam logic [3:0]  A_MASK   = 4'h6;
  localparam logic [3:0]  A_INCNT  = 4'h7;
  localparam logic [3:0]  A_OUTCNT = 4'h8;
  localparam logic [3:0]  A_STATE  = 4'h9;
  // ------------------------------------------------------------
  // control bits
  // ------------------------------------------------------------
  localparam int          C_INHIBIT = 0;
  localparam int          C_CLRERR  = 1;
  localparam int          C_INDIR   = 2;
  localparam int          C_OUTDIR  = 3;
  localparam int          C_REFSRC  = 4;
  localparam int          C_FMT     = 5;
  localparam int          C_TRI     = 6;
  localparam int          C_COMPEN  = 8;
  localparam logic        INHIBIT_RST = 1'b1;
  localparam logic        REF_ENC   = 1'b0;
  localparam logic        FMT_DIG   = 1'b0;
  // status bits
  localparam int          S_INERR  = 0;
  localparam int          S_FOLLOW = 1;
  localparam int          S_REF    = 2;
  localparam int          S_REJECT = 3;
  localparam int          S_W      = 4;
  // resolution field positions
  localparam int          R_ENC = 0;
  localparam int          R_IN  = 4;
  localparam int          R_OUT = 8;
  localparam int          R_LIM = 12;
  localparam int          LIM_SETTINGS = 11;
  localparam int          MAX_SHIFT    = 3;
  // allowed input resolution codes per encoder type, one bit per code
  localparam logic [7:0]  ENC_RES_MASK [4] = '{8'h0f, 8'h1e, 8'h3c, 8'hf0};
  typedef enum logic {MODE_CFG, MODE_COMP} mode_t;
endpackage

// *** qca_axis.sv ***
// one axis: encoder sampling, count scaling, compensated quadrature output
//
// Our own choices: the placing of the registers and the plain strobed port.
module qca_axis
  import qca_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [3:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  output logic                   irq,
  input  wire logic              inhibit_strap,
  input  wire logic              enc_a,
  input  wire logic              enc_b,
  input  wire logic              ref_p,
  input  wire logic              ref_n,
  input  wire logic              ext_ref_switch_port,
  output logic                   quad_a_p,
  output logic                   quad_a_n,
  output logic                   quad_b_p,
  output logic                   quad_b_n,
  output logic                   quad_oe,
  output logic      [1:0]        ana_phase,
  output logic                   ana_en
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [1:0] phase_of(input logic a, input logic b);
    phase_of = {a, a ^ b};
  endfunction

  function automatic logic [CNT_W-1:0] limit_of(input logic [3:0] s);
    limit_of = CNT_W'(1) << s;
  endfunction

  logic [31:0]       ctrl_q;
  logic [7:0]        in_div_q, out_div_q;
  logic [15:0]       res_q;
  logic [15:0]       comp_q [4];
  logic [S_W-1:0]    stat_q, mask_q, ev;
  logic              inhibit_q, strap_done_q, err_q;
  mode_t             mode_q;
  logic [7:0]        in_cnt_q, out_cnt_q;
  logic              in_tick, out_tick;
  logic [1:0]        in_ph_q, delta;
  logic              ref_q;
  logic [CNT_W-1:0]  acc_q, pos_q, target, diff;
  logic              step_up, step_dn, ref_now;
  logic              tri_en;

  wire wr_ctrl = wr && addr == A_CTRL;
  wire wr_rate = wr && addr == A_RATE;
  wire wr_res  = wr && addr == A_RES;
  wire digital = ctrl_q[C_FMT] == FMT_DIG;

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // control word; inhibit and tri-state handled separately
  always_ff @(posedge clk)
    if (reset)
      ctrl_q <= 32'h0000_0000;
    else if (wr_ctrl)
      ctrl_q <= wdata;

  // option exists only for digital output
  assign tri_en = ctrl_q[C_TRI] && digital;

  // stored inhibit caught after reset release, then software-owned
  always_ff @(posedge clk)
    if (reset)
    begin
      inhibit_q    <= INHIBIT_RST;
      strap_done_q <= 1'b0;
    end
    else
    begin
      strap_done_q <= 1'b1;
      if (!strap_done_q)
        inhibit_q <= inhibit_strap;
      else if (wr_ctrl)
        inhibit_q <= wdata[C_INHIBIT];
    end

  // rate dividers; zero is refused
  always_ff @(posedge clk)
    if (reset)
    begin
      in_div_q  <= IN_DIV_RST;
      out_div_q <= OUT_DIV_RST;
    end
    else if (wr_rate && wdata[7:0] != 8'h00 && wdata[15:8] != 8'h00)
    begin
      in_div_q  <= wdata[7:0];
      out_div_q <= wdata[15:8];
    end

  // resolutions and limit; invalid combinations rejected
  wire [3:0] w_in  = wdata[R_IN+:4];
  wire [3:0] w_out = wdata[R_OUT+:4];
  wire       res_ok = w_in < 4'h8 && w_out < 4'h8
                      && ENC_RES_MASK[wdata[R_ENC+:2]][w_in[2:0]]
                      && (w_out >= w_in ? w_out - w_in : w_in - w_out) <= 4'(MAX_SHIFT)
                      && wdata[R_LIM+:4] < 4'(LIM_SETTINGS);
  always_ff @(posedge clk)
    if (reset)
      res_q <= 16'h0000;
    else if (wr_res && res_ok)
      res_q <= wdata[15:0];

  // per-mode correction words from the compensation engine
  always_ff @(posedge clk)
    if (reset)
      comp_q <= '{default: 16'h0000};
    else if (wr && addr == A_COMP01)
      {comp_q[1], comp_q[0]} <= wdata;
    else if (wr && addr == A_COMP23)
      {comp_q[3], comp_q[2]} <= wdata;

  // ------------------------------------------------------------
  // mode control
  // ------------------------------------------------------------
  always_ff @(posedge clk)
    if (reset)
      mode_q <= MODE_CFG;
    else
      case (mode_q)
        MODE_CFG:  if (strap_done_q && !inhibit_q) mode_q <= MODE_COMP;
        MODE_COMP: if (inhibit_q) mode_q <= MODE_CFG;
        default:   mode_q <= MODE_CFG;
      endcase

  // ------------------------------------------------------------
  // rate ticks
  // ------------------------------------------------------------
  assign in_tick  = in_cnt_q == 8'h00;
  assign out_tick = out_cnt_q == 8'h00;
  always_ff @(posedge clk)
    if (reset)
    begin
      in_cnt_q  <= 8'h00;
      out_cnt_q <= 8'h00;
    end
    else
    begin
      in_cnt_q  <= in_tick ? in_div_q - 8'h01 : in_cnt_q - 8'h01;
      out_cnt_q <= out_tick ? out_div_q - 8'h01 : out_cnt_q - 8'h01;
    end

  // ------------------------------------------------------------
  // input decode
  // ------------------------------------------------------------
  assign delta   = phase_of(enc_a, enc_b) - in_ph_q;
  assign step_up = in_tick && (ctrl_q[C_INDIR] ? delta == 2'h3 : delta == 2'h1);
  assign step_dn = in_tick && (ctrl_q[C_INDIR] ? delta == 2'h1 : delta == 2'h3);
  assign ref_now = ctrl_q[C_REFSRC] == REF_ENC ? (ref_p && !ref_n) : ext_ref_switch_port;

  // sampled phase, reference level and accumulated count
  always_ff @(posedge clk)
    if (reset)
    begin
      in_ph_q <= 2'h0;
      ref_q   <= 1'b0;
      acc_q   <= '0;
    end
    else if (in_tick)
    begin
      in_ph_q <= phase_of(enc_a, enc_b);
      ref_q   <= ref_now;
      if (step_up)
        acc_q <= acc_q + CNT_W'(1);
      else if (step_dn)
        acc_q <= acc_q - CNT_W'(1);
    end

  // ------------------------------------------------------------
  // scaling and compensation
  // ------------------------------------------------------------
  always_comb
  begin
    logic [3:0] ri, ro;
    ri = res_q[R_IN+:4];
    ro = res_q[R_OUT+:4];
    target = ro >= ri ? acc_q << (ro - ri) : CNT_W'($signed(acc_q) >>> (ri - ro));
    for (int i = 0; i < 4; i++)
      if (ctrl_q[C_COMPEN+i] && mode_q == MODE_COMP)
        target = target + CNT_W'($signed(comp_q[i]));
  end
  assign diff = target - pos_q;

  // ------------------------------------------------------------
  // output generator
  // ------------------------------------------------------------
  // one step per tick in compensation mode; realign silently in config
  always_ff @(posedge clk)
    if (reset)
      pos_q <= '0;
    else if (mode_q == MODE_CFG)
      pos_q <= target;
    else if (out_tick && diff != '0)
      pos_q <= diff[CNT_W-1] ? pos_q - CNT_W'(1) : pos_q + CNT_W'(1);

  // drivers; phase order swapped for inverted sense
  always_ff @(posedge clk)
    if (reset)
    begin
      quad_a_p  <= 1'b0;
      quad_b_p  <= 1'b0;
      ana_phase <= 2'h0;
    end
    else
    begin
      quad_a_p  <= ctrl_q[C_OUTDIR] ? pos_q[1] ^ pos_q[0] : pos_q[1];
      quad_b_p  <= ctrl_q[C_OUTDIR] ? pos_q[1] : pos_q[1] ^ pos_q[0];
      ana_phase <= ctrl_q[C_OUTDIR] ? 2'h0 - pos_q[1:0] : pos_q[1:0];
    end
  assign quad_a_n = !quad_a_p;
  assign quad_b_n = !quad_b_p;

  // format select and float on error
  always_ff @(posedge clk)
    if (reset)
    begin
      quad_oe <= 1'b0;
      ana_en  <= 1'b0;
    end
    else
    begin
      quad_oe <= digital && !(tri_en && err_q);
      ana_en  <= !digital;
    end

  // ------------------------------------------------------------
  // errors and interrupts
  // ------------------------------------------------------------
  always_comb
  begin
    ev           = '0;
    ev[S_INERR]  = in_tick && delta == 2'h2;
    ev[S_FOLLOW] = mode_q == MODE_COMP
                   && (diff[CNT_W-1] ? -diff : diff) > limit_of(res_q[R_LIM+:4]);
    ev[S_REF]    = in_tick && ref_now && !ref_q;
    ev[S_REJECT] = (wr_res && !res_ok) || (wr_rate && (wdata[7:0] == 8'h00 || wdata[15:8] == 8'h00));
  end

  // error stands until cleared; a new error wins over the clear
  always_ff @(posedge clk)
    if (reset)
      err_q <= 1'b0;
    else
      err_q <= ev[S_INERR] || ev[S_FOLLOW] || (err_q && !(wr_ctrl && wdata[C_CLRERR]));

  // sticky status, cleared by read, set wins
  always_ff @(posedge clk)
    if (reset)
    begin
      stat_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      stat_q <= ((rd && addr == A_STAT) ? '0 : stat_q) | ev;
      if (wr && addr == A_MASK)
        mask_q <= wdata[S_W-1:0];
    end
  assign irq = |(stat_q & mask_q);

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  always_ff @(posedge clk)
    if (reset)
      rdata <= 32'h0000_0000;
    else if (rd)
      case (addr)
        A_CTRL:   rdata <= {ctrl_q[31:C_TRI+1], tri_en, ctrl_q[C_FMT:C_INDIR], 1'b0, inhibit_q};
        A_RATE:   rdata <= {16'h0000, out_div_q, in_div_q};
        A_RES:    rdata <= {16'h0000, res_q};
        A_COMP01: rdata <= {comp_q[1], comp_q[0]};
        A_COMP23: rdata <= {comp_q[3], comp_q[2]};
        A_STAT:   rdata <= {28'h0000000, stat_q};
        A_MASK:   rdata <= {28'h0000000, mask_q};
        A_INCNT:  rdata <= acc_q;
        A_OUTCNT: rdata <= pos_q;
        A_STATE:  rdata <= {29'h00000000, quad_oe, err_q, mode_q == MODE_COMP};
        default:  rdata <= 32'h0000_0000;
      endcase
    else
      rdata <= 32'h0000_0000;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_in_rate;
    @(posedge clk) disable iff (reset)
    (in_tick && in_div_q == IN_DIV_RST) |=> !in_tick [*7] ##1 in_tick;
  endproperty
  a_in_rate: assert property (p_in_rate) else $error("input sample tick spacing wrong");

  property p_in_dir;
    @(posedge clk) disable iff (reset)
    (in_tick && delta == 2'h1 && !ctrl_q[C_INDIR]) |=> acc_q == $past(acc_q) + CNT_W'(1);
  endproperty
  a_in_dir: assert property (p_in_dir) else $error("forward step did not count up");

  property p_ref_ext;
    @(posedge clk) disable iff (reset)
    (in_tick && ctrl_q[C_REFSRC] != REF_ENC && ext_ref_switch_port && !ref_q) |=> stat_q[S_REF];
  endproperty
  a_ref_ext: assert property (p_ref_ext) else $error("external reference edge missed");

  property p_out_rate;
    @(posedge clk) disable iff (reset)
    (out_tick && out_div_q > 8'h01) |=> !out_tick;
  endproperty
  a_out_rate: assert property (p_out_rate) else $error("update ticks too close");

  property p_step_tick;
    @(posedge clk) disable iff (reset)
    (mode_q == MODE_COMP && $past(mode_q) == MODE_COMP && pos_q != $past(pos_q))
      |-> $past(out_tick) && (pos_q - $past(pos_q) == CNT_W'(1) || $past(pos_q) - pos_q == CNT_W'(1));
  endproperty
  a_step_tick: assert property (p_step_tick) else $error("output step outside tick or too large");

  property p_float;
    @(posedge clk) disable iff (reset)
    (err_q && tri_en) |=> !quad_oe;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven during error");

  property p_tri_ana;
    @(posedge clk) disable iff (reset)
    !digital |-> !tri_en ##1 !quad_oe && ana_en;
  endproperty
  a_tri_ana: assert property (p_tri_ana) else $error("digital drivers active in analogue format");

  property p_inhibit;
    @(posedge clk) disable iff (reset)
    (strap_done_q && inhibit_q) |=> mode_q == MODE_CFG;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("compensation mode while inhibited");

  property p_illegal;
    @(posedge clk) disable iff (reset)
    (in_tick && delta == 2'h2) |=> stat_q[S_INERR] && err_q && acc_q == $past(acc_q);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal input change not flagged");
endmodule // qca_axis

// *** qca_far_end.sv ***
// encoder and motion controller stand-ins for one axis
module qca_far_end
(
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               step,
  input  wire logic               down,
  input  wire logic               jump,
  input  wire logic               clr,
  input  wire logic               quad_a_p,
  input  wire logic               quad_b_p,
  input  wire logic               quad_oe,
  output logic                    enc_a,
  output logic                    enc_b,
  output logic signed [31:0]      ctl_cnt,
  output logic                    fast
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_q;
  logic [1:0] seen_q;
  logic [1:0] now;
  logic [7:0] gap_q;
  // ---------------------------------------------
  // encoder: one legal step, or a forced two-step jump
  // ---------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      ph_q <= 2'h0;
    else if (jump)
      ph_q <= ph_q + 2'h2;
    else if (step)
      ph_q <= down ? ph_q - 2'h1 : ph_q + 2'h1;
  end
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  // ---------------------------------------------
  // controller: decode steps, flag edges closer than one tick
  // ---------------------------------------------
  assign now = {quad_a_p, quad_a_p ^ quad_b_p};
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctl_cnt <= '0;
      seen_q  <= 2'h0;
      gap_q   <= 8'h0;
      fast    <= 1'b0;
    end
    else
    begin
      if (clr) fast <= 1'b0;
      if (quad_oe)
      begin
        seen_q <= now;
        gap_q  <= (now != seen_q) ? 8'h0 : gap_q + 8'(gap_q != 8'hff);
        if (now == seen_q + 2'h1) ctl_cnt <= ctl_cnt + 1;
        if (now == seen_q - 2'h1) ctl_cnt <= ctl_cnt - 1;
        if (now != seen_q && gap_q < 8'h7) fast <= 1'b1;
      end
    end
  end
endmodule // qca_far_end

// *** tb.sv ***
// self-checking bench for one compensated quadrature axis
module tb
  import qca_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [3:0] a; logic [31:0] v;} row_t;
  logic clk, reset, wr, rd, inhibit_strap, ref_p, ref_n, ext_ref_switch_port;
  logic step, down, jump, clr, enc_a, enc_b, irq, ana_en, fast;
  logic quad_a_p, quad_a_n, quad_b_p, quad_b_n, quad_oe;
  logic [3:0]         addr;
  logic [31:0]        wdata, rdata, v;
  logic [1:0]         ana_phase;
  logic signed [31:0] ctl_cnt, base;
  int                 fails, n_checks;
  row_t rows [7] = '{'{A_RATE, 32'h0808}, '{A_RES, 32'h0}, '{A_COMP01, 32'h0}, '{A_COMP23, 32'h0},
                     '{A_STAT, 32'h0}, '{A_MASK, 32'h0}, '{4'hf, 32'h0}};
  logic [31:0] bad [3] = '{32'h4710, 32'hb310, 32'h0001};

  qca_axis qca_axis_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .inhibit_strap(inhibit_strap), .enc_a(enc_a), .enc_b(enc_b),
    .ref_p(ref_p), .ref_n(ref_n), .ext_ref_switch_port(ext_ref_switch_port), .quad_a_p(quad_a_p),
    .quad_a_n(quad_a_n), .quad_b_p(quad_b_p), .quad_b_n(quad_b_n), .quad_oe(quad_oe),
    .ana_phase(ana_phase), .ana_en(ana_en));
  qca_far_end qca_far_end_inst (.clk(clk), .reset(reset), .step(step), .down(down), .jump(jump),
    .clr(clr), .quad_a_p(quad_a_p), .quad_b_p(quad_b_p), .quad_oe(quad_oe), .enc_a(enc_a),
    .enc_b(enc_b), .ctl_cnt(ctl_cnt), .fast(fast));

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // encoder moves n steps, one every 17 clocks
  task automatic enc(input int n, input logic dn);
    repeat (n)
    begin
      @(posedge clk);
      step <= 1'b1;
      down <= dn;
      tick(1);
      step <= 1'b0;
      tick(15);
    end
  endtask
  // reference mark on the encoder pair or the switch port
  task automatic ref_pulse(input logic ext);
    rd_reg(A_STAT);
    if (ext) ext_ref_switch_port <= 1'b1;
    else {ref_p, ref_n} <= 2'b10;
    tick(20);
    {ref_p, ref_n, ext_ref_switch_port} <= 3'b010;
    tick(5);
    rd_reg(A_STAT);
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ---------------------------------------------
  // clock and watchdog
  // ---------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    tick(40000);
    fails++;
    wrap_up;
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    {reset, inhibit_strap, ref_n} = 3'b111;
    {wr, rd, ref_p, ext_ref_switch_port, step, down, jump, clr} = '0;
    addr = 4'h0;
    wdata = 32'h0;
    fails = 0;
    n_checks = 0;
    tick(20);
    reset <= 1'b0;
    tick(5);
    foreach (rows[i])
    begin
      rd_reg(rows[i].a);
      chk(v, rows[i].v);
    end
    rd_reg(A_STATE);
    chk(v & 32'h1, 32'h0);
    // counting and input sense, still configuring
    enc(3, 1'b0);
    rd_reg(A_INCNT);
    chk(v, 32'h3);
    wr_reg(A_CTRL, 32'h05);
    enc(2, 1'b0);
    rd_reg(A_INCNT);
    chk(v, 32'h1);
    wr_reg(A_RES, 32'h4310);
    wr_reg(A_CTRL, 32'h00);
    tick(10);
    rd_reg(A_STATE);
    chk(v & 32'h1, 32'h1);
    chk(32'({quad_oe, quad_a_n ^ quad_a_p, quad_b_n ^ quad_b_p, ana_en}), 32'he);
    // four output steps per input step, rate limited
    base = ctl_cnt;
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    enc(4, 1'b0);
    tick(100);
    chk(ctl_cnt - base, 32'd16);
    chk(32'(fast), 32'h0);
    wr_reg(A_CTRL, 32'h08);
    tick(20);
    base = ctl_cnt;
    enc(2, 1'b0);
    tick(60);
    chk(ctl_cnt - base, 32'hffff_fff8);
    wr_reg(A_CTRL, 32'h00);
    // invalid resolution settings are refused
    foreach (bad[i])
    begin
      rd_reg(A_STAT);
      wr_reg(A_RES, bad[i]);
      rd_reg(A_STAT);
      chk(v & 32'h8, 32'h8);
    end
    rd_reg(A_RES);
    chk(v, 32'h4310);
    // only enabled compensation words move the output
    wr_reg(A_COMP01, 32'h5);
    tick(20);
    base = ctl_cnt;
    wr_reg(A_CTRL, 32'h100);
    tick(80);
    chk(ctl_cnt - base, 32'd5);
    wr_reg(A_CTRL, 32'h200);
    tick(80);
    chk(ctl_cnt - base, 32'd0);
    // illegal input change, interrupt and tri-state
    wr_reg(A_MASK, 32'h1);
    wr_reg(A_CTRL, 32'h40);
    rd_reg(A_STAT);
    tick(5);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    jump <= 1'b1;
    tick(1);
    jump <= 1'b0;
    tick(30);
    chk(32'({irq, quad_oe}), 32'h2);
    rd_reg(A_STAT);
    chk(v & 32'h1, 32'h1);
    tick(2);
    chk(32'(irq), 32'h0);
    wr_reg(A_CTRL, 32'h42);
    tick(5);
    chk(32'(quad_oe), 32'h1);
    wr_reg(A_CTRL, 32'h60);
    tick(5);
    chk(32'({ana_en, quad_oe}), 32'h2);
    // analogue quadrant follows the two low bits of the output count
    rd_reg(A_OUTCNT);
    chk(32'(ana_phase), v & 32'h3);
    rd_reg(A_CTRL);
    chk(v & 32'h40, 32'h0);
    // following error above the selected limit
    rd_reg(A_STAT);
    wr_reg(A_COMP01, 32'h100);
    wr_reg(A_CTRL, 32'h100);
    tick(30);
    rd_reg(A_STAT);
    chk(v & 32'h2, 32'h2);
    // reference source selection
    ref_pulse(1'b0);
    chk(v & 32'h4, 32'h4);
    wr_reg(A_CTRL, 32'h110);
    ref_pulse(1'b0);
    chk(v & 32'h4, 32'h0);
    ref_pulse(1'b1);
    chk(v & 32'h4, 32'h4);
    // power-up straight into compensation
    inhibit_strap <= 1'b0;
    reset <= 1'b1;
    tick(20);
    reset <= 1'b0;
    tick(5);
    rd_reg(A_STATE);
    chk(v & 32'h1, 32'h1);
    wrap_up;
  end
endmodule // tb
